//--- common/dhi_pkg.sv
// constants, field layouts and carrier types of the display host interface
// assumes a single 20 MHz clock; all times below are converted to cycles here
package dhi_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_NS = 50;
	localparam int CLEAR_MAX_NS = 100000;
	localparam int CLEAR_MAX_CYC = CLEAR_MAX_NS / CLK_NS;
	localparam int RST_HOLD_NS = 10000;
	localparam int RST_HOLD_CYC_I = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_W = 8;
	localparam logic [RST_W-1:0] RST_HOLD_CYC = RST_HOLD_CYC_I[RST_W-1:0];
	localparam int BUSY_W = 12;
	localparam logic [BUSY_W-1:0] EXEC_CYC_DEF = 12'h014;

	// ------------------------------------------------------------------
	// stores
	// ------------------------------------------------------------------
	localparam int TEXT_AW = 7;
	localparam int GLYPH_AW = 6;
	localparam int GLYPH_DW = 5;
	localparam logic [TEXT_AW-1:0] TEXT_LAST = 7'h7f;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [2:0] UNDERLINE_ROW = 3'h7;
	localparam logic [GLYPH_DW-1:0] UNDERLINE_MASK = 5'h04;

	// ------------------------------------------------------------------
	// instruction fields
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_CLEAR = 8'h01;
	localparam int IF_BIT = 4;
	localparam int D_BIT = 2;
	localparam int C_BIT = 1;
	localparam int B_BIT = 0;
	localparam int ID_BIT = 1;
	localparam int S_BIT = 0;
	localparam int RL_BIT = 2;

	// ------------------------------------------------------------------
	// serial start byte, first bit shifted in lands in bit 7
	// ------------------------------------------------------------------
	localparam logic [4:0] SYNC_ONES = 5'h1f;
	localparam int SB_RW = 2;
	localparam int SB_RS = 1;
	localparam int SB_END = 0;
	localparam logic [4:0] SER_BYTE1_LAST = 5'h07;
	localparam logic [4:0] SER_BYTE2_FIRST = 5'h08;
	localparam logic [4:0] SER_BYTE2_LAST = 5'h0f;
	localparam logic [4:0] SER_DONE = 5'h10;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic rs;
		logic rw;
		logic [7:0] data;
	} dhi_xfer_t;

	typedef struct packed {
		logic display_on;
		logic cursor_on;
		logic blink_on;
		logic entry_inc;
		logic entry_shift;
		logic bus_8bit;
		logic [1:0] luminance;
	} dhi_mode_t;

	localparam dhi_mode_t MODE_RESET = '{display_on: 1'h0, cursor_on: 1'h0,
		blink_on: 1'h0, entry_inc: 1'h1, entry_shift: 1'h0,
		bus_8bit: 1'h1, luminance: 2'h0};

endpackage

//--- rtl/dhi_mem.sv
// small store with one write port and two registered read ports
// assumes writes and reads share mclk; contents are not reset
`timescale 1ns/1ps
module dhi_mem #(
	parameter int AW = 6,
	parameter int DW = 5
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	output logic [DW-1:0] rdata_a,
	input wire logic [AW-1:0] raddr_b,
	output logic [DW-1:0] rdata_b
);
	logic [DW-1:0] cells [0:(1<<AW)-1];

	always_ff @(posedge mclk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
	end

	// read data leave from flops so the top sees registered values
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_a <= '0;
			rdata_b <= '0;
		end else begin
			rdata_a <= cells[raddr_a];
			rdata_b <= cells[raddr_b];
		end
	end
endmodule // dhi_mem

//--- rtl/dhi_top.sv
// host command and data interface of a two-line text display controller
// assumes all pins are synchronous to mclk; straps are static levels
//
// Contract
// - status read: busy on msb, pointer below
// - pointer targets store of last set-address
// - pointer already updated when busy clears
// - busy one while executing, zero when ready
// - glyph store: eight glyphs, eight rows, five dots
// - glyph address char/row; codes alias modulo eight
// - eighth row keeps only underline dot
// - power-on fills text with spaces, busy
// - reset: pointer zero, text store target
// - reset: display, cursor, blink off
// - reset: increment, no shift, 8-bit, full brightness
// - 4-bit mode: two nibbles, high first
// - serial accepted only while strobe low
// - start byte: sync, direction, select, end bit
// - select 0 instruction, 1 data; direction 1 read
// - second byte written, or returned on read
// - serial read data changes on falling clock
// - interface strap picks parallel or serial
// - style strap picks enable or split strobes
// - strapped low reset over 10 us resets
// - width bit: 8 lines or upper four
`timescale 1ns/1ps
module dhi_top #(
	parameter logic [dhi_pkg::BUSY_W-1:0] EXEC_CYC = dhi_pkg::EXEC_CYC_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic interface_strap,
	input wire logic bus_style_strap,
	input wire logic reset_strap,
	input wire logic ext_reset_n,
	input wire logic par_rs,
	input wire logic par_dir_wr_n,
	input wire logic par_en_rd_n,
	input wire logic [7:0] par_data_in,
	output logic [7:0] par_data_out,
	output logic par_data_oe,
	input wire logic serial_strobe_n,
	input wire logic ser_clk,
	input wire logic ser_in,
	output logic ser_out,
	output logic ser_oe,
	input wire logic [dhi_pkg::TEXT_AW-1:0] scan_text_addr,
	output logic [7:0] scan_text_char,
	input wire logic [7:0] scan_glyph_code,
	input wire logic [2:0] scan_glyph_row,
	output logic [dhi_pkg::GLYPH_DW-1:0] scan_glyph_dots,
	output dhi_pkg::dhi_mode_t mode,
	output logic busy_indicator
);
	import dhi_pkg::*;

	typedef enum logic [2:0] {
		ST_CLEAR = 3'h1,
		ST_IDLE = 3'h2,
		ST_BUSY = 3'h4
	} dhi_state_t;

	dhi_state_t state, next_state;
	logic [TEXT_AW-1:0] ptr;
	logic glyph_target;
	logic bright_armed;
	logic [TEXT_AW-1:0] clr_addr;
	logic [BUSY_W-1:0] busy_cnt;
	logic [7:0] text_q;
	logic [GLYPH_DW-1:0] glyph_q;

	// ------------------------------------------------------------------
	// read values
	// ------------------------------------------------------------------
	wire [7:0] status_word = {busy_indicator, ptr};
	wire [7:0] store_word = glyph_target ? {3'h0, glyph_q} : text_q;

	// ------------------------------------------------------------------
	// parallel bus
	// ------------------------------------------------------------------
	logic wr_act_q, rd_act_q, par_rs_q, rd_rs_q, nib_phase;
	logic [7:0] par_latch, rd_snap;
	logic [3:0] nib_hi;
	wire par_sel = ~interface_strap;
	wire split = bus_style_strap;
	wire par_wr_act = par_sel & (split ? ~par_dir_wr_n
		: (par_en_rd_n & ~par_dir_wr_n));
	wire par_rd_act = par_sel & (split ? ~par_en_rd_n
		: (par_en_rd_n & par_dir_wr_n));
	wire par_wr_end = wr_act_q & ~par_wr_act;
	wire par_rd_start = par_rd_act & ~rd_act_q;
	wire par_rd_end = rd_act_q & ~par_rd_act;
	// serial transfers ignore the width bit, so a cleared bit cannot hurt
	wire nib_mode = ~mode.bus_8bit;
	wire [7:0] par_wr_byte = nib_mode ? {nib_hi, par_latch[7:4]}
		: par_latch;
	wire par_wr_done = par_wr_end & (~nib_mode | nib_phase);
	wire par_rd_done = par_rd_end & (~nib_mode | nib_phase);
	wire [7:0] par_rd_value = par_rs ? store_word : status_word;
	wire [7:0] par_rd_lane = ~nib_mode ? par_rd_value
		: (nib_phase ? {rd_snap[3:0], 4'h0}
		: {par_rd_value[7:4], 4'h0});

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_act_q <= 1'h0;
			rd_act_q <= 1'h0;
			par_latch <= 8'h00;
			par_rs_q <= 1'h0;
			rd_rs_q <= 1'h0;
		end else begin
			wr_act_q <= par_wr_act;
			rd_act_q <= par_rd_act;
			if (par_wr_act) begin
				par_latch <= par_data_in;
				par_rs_q <= par_rs;
			end
			if (par_rd_start) begin
				rd_rs_q <= par_rs;
			end
		end
	end

	// nibble phase is shared by reads and writes; no busy gap is needed
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			nib_phase <= 1'h0;
			nib_hi <= 4'h0;
			rd_snap <= 8'h00;
			par_data_out <= 8'h00;
			par_data_oe <= 1'h0;
		end else begin
			if (nib_mode && (par_wr_end || par_rd_end)) begin
				nib_phase <= ~nib_phase;
			end
			if (par_wr_end && !nib_phase) begin
				nib_hi <= par_latch[7:4];
			end
			if (par_rd_start) begin
				par_data_out <= par_rd_lane;
				if (!(nib_mode && nib_phase)) begin
					rd_snap <= par_rd_value;
				end
			end
			par_data_oe <= par_rd_act;
		end
	end

	// ------------------------------------------------------------------
	// serial link
	// ------------------------------------------------------------------
	logic sclk_q, s_drop, s_rw, s_rs;
	logic [4:0] s_cnt;
	logic [7:0] s_sr, s_out;
	wire ser_act = interface_strap & ~serial_strobe_n;
	wire sclk_rise = ser_clk & ~sclk_q;
	wire sclk_fall = ~ser_clk & sclk_q;
	wire [7:0] s_byte = {s_sr[6:0], ser_in};
	wire s_sync_ok = (s_byte[7:3] == SYNC_ONES)
		& ~s_byte[SB_END];
	wire s_take = ser_act & sclk_rise & ~s_drop & (s_cnt < SER_DONE);
	wire s_first = s_take & (s_cnt == SER_BYTE1_LAST);
	wire s_last = s_take & (s_cnt == SER_BYTE2_LAST);
	wire s_wr_done = s_last & ~s_rw;
	wire s_rd_done = s_last & s_rw;
	wire s_shift_out = ser_act & sclk_fall & s_rw & ~s_drop
		& (s_cnt >= SER_BYTE2_FIRST) & (s_cnt <= SER_BYTE2_LAST);
	wire [7:0] ser_rd_value = s_byte[SB_RS] ? store_word
		: status_word;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'h1;
			s_cnt <= 5'h00;
			s_drop <= 1'h0;
			s_rw <= 1'h0;
			s_rs <= 1'h0;
			s_sr <= 8'h00;
			s_out <= 8'h00;
			ser_out <= 1'h0;
			ser_oe <= 1'h0;
		end else begin
			sclk_q <= ser_clk;
			if (!ser_act) begin
				s_cnt <= 5'h00;
				s_drop <= 1'h0;
				s_rw <= 1'h0;
				ser_oe <= 1'h0;
			end else begin
				if (s_take) begin
					s_sr <= s_byte;
					s_cnt <= s_cnt + 5'h01;
				end
				if (s_first) begin
					s_drop <= ~s_sync_ok;
					s_rw <= s_byte[SB_RW];
					s_rs <= s_byte[SB_RS];
					s_out <= ser_rd_value;
				end
				if (s_shift_out) begin
					ser_out <= s_out[7];
					s_out <= {s_out[6:0], 1'h0};
					ser_oe <= 1'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// request merge and decode
	// ------------------------------------------------------------------
	dhi_xfer_t req;
	assign req.rs = par_wr_done ? par_rs_q : (par_rd_done ? rd_rs_q : s_rs);
	assign req.rw = par_rd_done | s_rd_done;
	assign req.data = par_wr_done ? par_wr_byte : s_byte;
	// writes and data reads arriving while busy are dropped, status reads are answered; the host is expected to poll
	wire go = (state == ST_IDLE) & (par_wr_done | s_wr_done
		| ((par_rd_done | s_rd_done) & req.rs));
	wire go_cmd = go & ~req.rs & ~req.rw;
	wire go_data_wr = go & req.rs & ~req.rw;
	wire bright_wr = go_data_wr & bright_armed;
	wire store_wr = go_data_wr & ~bright_armed;
	wire store_rd = go & req.rs & req.rw;
	wire is_clear = req.data == CMD_CLEAR;
	wire is_entry = req.data[7:2] == 6'h01;
	wire is_ctrl = req.data[7:3] == 5'h01;
	wire is_shift = req.data[7:4] == 4'h1;
	wire is_func = req.data[7:5] == 3'h1;
	wire is_gaddr = req.data[7:6] == 2'h1;
	wire is_taddr = req.data[7];
	wire step_up = (go_cmd & is_shift) ? req.data[RL_BIT] : mode.entry_inc;
	wire [TEXT_AW-1:0] ptr_up = ptr + 7'h01;
	wire [TEXT_AW-1:0] ptr_dn = ptr - 7'h01;
	wire [TEXT_AW-1:0] ptr_step_raw = step_up ? ptr_up : ptr_dn;
	// glyph pointer wraps in six bits
	wire [TEXT_AW-1:0] ptr_stepped = glyph_target
		? {1'h0, ptr_step_raw[GLYPH_AW-1:0]} : ptr_step_raw;

	// ------------------------------------------------------------------
	// stores
	// ------------------------------------------------------------------
	wire clearing = state == ST_CLEAR;
	wire text_we = clearing | (store_wr & ~glyph_target);
	wire [TEXT_AW-1:0] text_waddr = clearing ? clr_addr : ptr;
	wire [7:0] text_wdata = clearing ? SPACE_CODE : req.data;
	wire glyph_we = store_wr & glyph_target;
	wire underline_row = ptr[2:0] == UNDERLINE_ROW;
	wire [GLYPH_DW-1:0] glyph_wdata = underline_row
		? (req.data[GLYPH_DW-1:0] & UNDERLINE_MASK)
		: req.data[GLYPH_DW-1:0];

	dhi_mem #(.AW(TEXT_AW), .DW(8)) text_mem (
		.mclk(mclk),
		.rst(rst),
		.we(text_we),
		.waddr(text_waddr),
		.wdata(text_wdata),
		.raddr_a(ptr),
		.rdata_a(text_q),
		.raddr_b(scan_text_addr),
		.rdata_b(scan_text_char)
	);

	// codes 08..0f fold onto 00..07 by using only the low three bits
	dhi_mem #(.AW(GLYPH_AW), .DW(GLYPH_DW)) glyph_mem (
		.mclk(mclk),
		.rst(rst),
		.we(glyph_we),
		.waddr(ptr[GLYPH_AW-1:0]),
		.wdata(glyph_wdata),
		.raddr_a(ptr[GLYPH_AW-1:0]),
		.rdata_a(glyph_q),
		.raddr_b({scan_glyph_code[2:0], scan_glyph_row}),
		.rdata_b(scan_glyph_dots)
	);

	// ------------------------------------------------------------------
	// external reset strap
	// ------------------------------------------------------------------
	logic [RST_W-1:0] xr_cnt;
	wire xr_low = reset_strap & ~ext_reset_n;
	wire soft_rst = xr_low & (xr_cnt == RST_HOLD_CYC);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			xr_cnt <= '0;
		end else if (!xr_low) begin
			xr_cnt <= '0;
		end else if (xr_cnt <= RST_HOLD_CYC) begin
			xr_cnt <= xr_cnt + 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// executor
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_CLEAR: begin
				if (clr_addr == TEXT_LAST) next_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (go) next_state = (go_cmd & is_clear) ? ST_CLEAR : ST_BUSY;
			end
			ST_BUSY: begin
				if (busy_cnt == '0) next_state = ST_IDLE;
			end
			default: next_state = ST_CLEAR;
		endcase
		if (soft_rst) next_state = ST_CLEAR;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ST_CLEAR;
			busy_indicator <= 1'h1;
			busy_cnt <= '0;
			clr_addr <= '0;
		end else begin
			state <= next_state;
			busy_indicator <= next_state != ST_IDLE;
			if (soft_rst || (go_cmd && is_clear)) begin
				clr_addr <= '0;
			end else if (clearing) begin
				clr_addr <= clr_addr + 7'h01;
			end
			if (go) begin
				busy_cnt <= EXEC_CYC - 12'h001;
			end else if (state == ST_BUSY) begin
				busy_cnt <= busy_cnt - 12'h001;
			end
		end
	end

	// the pointer moves in the accepting cycle, long before busy clears
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ptr <= '0;
			glyph_target <= 1'h0;
			mode <= MODE_RESET;
			bright_armed <= 1'h0;
		end else if (soft_rst) begin
			ptr <= '0;
			glyph_target <= 1'h0;
			mode <= MODE_RESET;
			bright_armed <= 1'h0;
		end else begin
			if (go) bright_armed <= go_cmd & is_func;
			if (bright_wr) mode.luminance <= req.data[1:0];
			if (store_wr || store_rd || (go_cmd && is_shift)) begin
				ptr <= ptr_stepped;
			end
			if (go_cmd && is_taddr) begin
				ptr <= req.data[TEXT_AW-1:0];
				glyph_target <= 1'h0;
			end else if (go_cmd && is_gaddr) begin
				ptr <= {1'h0, req.data[GLYPH_AW-1:0]};
				glyph_target <= 1'h1;
			end else if (go_cmd && is_func) begin
				mode.bus_8bit <= req.data[IF_BIT];
			end else if (go_cmd && is_ctrl) begin
				mode.display_on <= req.data[D_BIT];
				mode.cursor_on <= req.data[C_BIT];
				mode.blink_on <= req.data[B_BIT];
			end else if (go_cmd && is_entry) begin
				mode.entry_inc <= req.data[ID_BIT];
				mode.entry_shift <= req.data[S_BIT];
			end else if (go_cmd && is_clear) begin
				ptr <= '0;
				glyph_target <= 1'h0;
			end
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	int clr_len;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) clr_len <= 0;
		else if (clearing) clr_len <= clr_len + 1;
		else clr_len <= 0;
	end

	sequence bad_start_s;
		s_first && !s_sync_ok;
	endsequence

	sequence silent_s;
		(!s_wr_done && !s_rd_done) [*8];
	endsequence

	status_read_a: assert property (par_rd_start && !par_rs && !nib_mode
		|=> par_data_out == $past({busy_indicator, ptr}))
		else $error("status read does not show busy and pointer");
	clear_busy_a: assert property (clearing |-> busy_indicator)
		else $error("busy low during text clear");
	clear_len_a: assert property (clr_len < CLEAR_MAX_CYC)
		else $error("text clear runs too long");
	clear_fill_a: assert property (clearing
		|-> text_we && text_wdata == SPACE_CODE)
		else $error("text clear writes a non-space");
	glyph_addr_a: assert property (go_cmd && is_gaddr
		|=> glyph_target && ptr == {1'h0, $past(req.data[5:0])})
		else $error("glyph address not loaded");
	underline_a: assert property (glyph_we && underline_row
		|-> (glyph_wdata & ~UNDERLINE_MASK) == '0)
		else $error("underline row lights a non-underline dot");
	soft_reset_a: assert property (soft_rst
		|=> clearing && ptr == '0 && !glyph_target)
		else $error("strapped reset did not reset");
	serial_drop_a: assert property (bad_start_s |=> silent_s)
		else $error("frame with bad start byte acted upon");
	ser_fall_a: assert property ($changed(ser_out) |-> $past(sclk_fall))
		else $error("serial output changed off a falling clock");
	busy_ptr_a: assert property ($fell(busy_indicator)
		|-> $stable(ptr) && $past(state) == ST_BUSY
		|| $past(state) == ST_CLEAR)
		else $error("pointer moved as busy cleared");
endmodule // dhi_top

//--- dv/dhi_ser_host.sv
// serial host model: sends two-byte frames on the synchronous link
// assumes the device samples on rising shift clock and answers on falling
`timescale 1ns/1ps
module dhi_ser_host (
	input wire logic mclk,
	input wire logic sdi,
	input wire logic sdi_oe,
	output logic strobe_n,
	output logic sclk,
	output logic sdo
);
	// shift clock stands still high between frames
	initial begin
		strobe_n = 1'b1;
		sclk = 1'b1;
		sdo = 1'b1;
	end

	// b1 is the start byte: sync ones, direction, select, end bit
	task automatic frame(input logic [7:0] b1, input logic [7:0] b2,
		output logic [7:0] rx);
		logic [15:0] sh;
		sh = {b1, b2};
		rx = 8'h00;
		@(negedge mclk);
		strobe_n = 1'b0;
		repeat (2) @(negedge mclk);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			// a released line toggles so stale data cannot match
			sdo = (b1[2] && i < 8) ? ~sdo : sh[i];
			repeat (3) @(negedge mclk);
			if (i < 8)
				rx[i] = sdi & sdi_oe;
			sclk = 1'b1;
			repeat (3) @(negedge mclk);
		end
		strobe_n = 1'b1;
		repeat (3) @(negedge mclk);
	endtask
endmodule // dhi_ser_host

//--- dv/tb_top.sv
// self-checking bench of the display host interface
// assumes dhi_top, dhi_mem and the serial host model are compiled first
`timescale 1ns/1ps
module tb_top;
	import dhi_pkg::*;

	logic mclk, rst, interface_strap, bus_style_strap, reset_strap;
	logic ext_reset_n, par_rs, par_dir_wr_n, par_en_rd_n;
	logic [7:0] par_data_in, par_data_out, scan_text_char, scan_glyph_code;
	logic par_data_oe, ser_strobe_n, ser_clk, ser_in, ser_out, ser_oe;
	logic [6:0] scan_text_addr;
	logic [2:0] scan_glyph_row;
	logic [4:0] scan_glyph_dots;
	dhi_mode_t mode, em;
	logic busy_indicator, bs, nib;
	logic [7:0] st, rx;
	logic [7:0] bad [3] = '{8'hea, 8'hfb, 8'h7a};
	int n_errors = 0;
	int comparisons = 0;

	dhi_top #(.EXEC_CYC(12'h010)) dut_u (.mclk(mclk), .rst(rst),
		.interface_strap(interface_strap), .bus_style_strap(bus_style_strap),
		.reset_strap(reset_strap), .ext_reset_n(ext_reset_n),
		.par_rs(par_rs), .par_dir_wr_n(par_dir_wr_n),
		.par_en_rd_n(par_en_rd_n), .par_data_in(par_data_in),
		.par_data_out(par_data_out), .par_data_oe(par_data_oe),
		.serial_strobe_n(ser_strobe_n), .ser_clk(ser_clk), .ser_in(ser_in),
		.ser_out(ser_out), .ser_oe(ser_oe), .scan_text_addr(scan_text_addr),
		.scan_text_char(scan_text_char), .scan_glyph_code(scan_glyph_code),
		.scan_glyph_row(scan_glyph_row), .scan_glyph_dots(scan_glyph_dots),
		.mode(mode), .busy_indicator(busy_indicator));

	dhi_ser_host host_u (.mclk(mclk), .sdi(ser_out), .sdi_oe(ser_oe),
		.strobe_n(ser_strobe_n),
		.sclk(ser_clk), .sdo(ser_in));

	// ------------------------------------------------------------------
	// clock, verdict, watchdog
	// ------------------------------------------------------------------
	initial mclk = 1'b0;
	always #25 mclk = ~mclk;

	task automatic finish_test;
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// the run needs well under 20000 cycles
	initial begin
		#(50 * 40000);
		n_errors++;
		finish_test;
	end

	// ------------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------------
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// bs selects split strobes; enable style keeps direction low past E fall
	task automatic wr(input logic rs, input logic [7:0] d);
		@(negedge mclk);
		par_rs = rs;
		par_data_in = d;
		par_dir_wr_n = 1'b0;
		par_en_rd_n = 1'b1;
		@(negedge mclk);
		if (bs)
			par_dir_wr_n = 1'b1;
		else
			par_en_rd_n = 1'b0;
		@(negedge mclk);
		par_dir_wr_n = 1'b1;
		par_data_in = ~d;
	endtask

	task automatic rd(input logic rs, output logic [7:0] q);
		@(negedge mclk);
		par_rs = rs;
		par_dir_wr_n = 1'b1;
		par_en_rd_n = ~bs;
		repeat (2) @(negedge mclk);
		q = par_data_out;
		cmp8({7'h0, par_data_oe}, 8'h01);
		par_en_rd_n = bs;
		@(negedge mclk);
	endtask

	task automatic wait_ready(output logic [7:0] s);
		logic [7:0] lo;
		s = 8'h80;
		for (int i = 0; i < 200 && s[7] !== 1'b0; i++) begin
			rd(1'b0, s);
			// 4-bit mode: low nibble of the same snapshot follows
			if (nib) begin
				rd(1'b0, lo);
				s = {s[7:4], lo[7:4]};
			end
		end
		cmp8({7'h0, s[7]}, 8'h00);
	endtask

	task automatic wait_busy(input int lim);
		int i;
		i = 0;
		repeat (2) @(negedge mclk);
		while (busy_indicator !== 1'b0 && i < lim) begin
			@(negedge mclk);
			i++;
		end
		cmp8({7'h0, busy_indicator}, 8'h00);
	endtask

	task automatic scan_t(input logic [6:0] a, input logic [7:0] exp);
		@(negedge mclk);
		scan_text_addr = a;
		repeat (2) @(negedge mclk);
		cmp8(scan_text_char, exp);
	endtask

	task automatic scan_g(input logic [7:0] c, input logic [2:0] r,
		input logic [4:0] exp);
		@(negedge mclk);
		scan_glyph_code = c;
		scan_glyph_row = r;
		repeat (2) @(negedge mclk);
		cmp8({3'h0, scan_glyph_dots}, {3'h0, exp});
	endtask

	task automatic do_reset;
		@(negedge mclk);
		rst = 1'b1;
		repeat (6) @(negedge mclk);
		cmp8({7'h0, busy_indicator}, 8'h01);
		cmp8(mode, MODE_RESET);
		rst = 1'b0;
		wait_busy(CLEAR_MAX_CYC);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{interface_strap, bus_style_strap, reset_strap, bs, nib} = 5'h00;
		{ext_reset_n, par_dir_wr_n, par_en_rd_n, par_rs} = 4'hc;
		par_data_in = 8'h00;
		scan_text_addr = 7'h00;
		scan_glyph_code = 8'h00;
		scan_glyph_row = 3'h0;
		do_reset;
		rd(1'b0, st);
		cmp8(st, 8'h00);
		scan_t(7'h00, SPACE_CODE);
		scan_t(TEXT_LAST, SPACE_CODE);
		wr(1'b0, 8'h85);
		rd(1'b0, st);
		cmp8({7'h0, st[7]}, 8'h01);
		wait_ready(st);
		wr(1'b1, 8'h41);
		wait_ready(st);
		cmp8(st, 8'h06);
		scan_t(7'h05, 8'h41);
		wr(1'b0, 8'h4f);
		wait_ready(st);
		wr(1'b1, 8'hff);
		wait_ready(st);
		cmp8(st, 8'h10);
		scan_g(8'h09, 3'h7, UNDERLINE_MASK);
		wr(1'b1, 8'he5);
		wait_ready(st);
		scan_g(8'h02, 3'h0, 5'h05);
		scan_g(8'h0a, 3'h0, 5'h05);
		// second command lands while busy and must be dropped
		wr(1'b0, 8'h0c);
		wr(1'b0, 8'h08);
		wait_ready(st);
		cmp8({7'h0, mode.display_on}, 8'h01);
		// nibble mode: back-to-back halves with no poll between them
		wr(1'b0, 8'h20);
		nib = 1'b1;
		wait_ready(st);
		cmp8({7'h0, mode.bus_8bit}, 8'h00);
		wr(1'b0, 8'h00);
		wr(1'b0, 8'hf0);
		wait_busy(200);
		em = MODE_RESET;
		em.bus_8bit = 1'b0;
		{em.display_on, em.cursor_on, em.blink_on} = 3'h7;
		cmp8(mode, em);
		wr(1'b0, 8'h30);
		wr(1'b0, 8'h00);
		nib = 1'b0;
		wait_busy(200);
		wr(1'b1, 8'h02);
		wait_busy(200);
		em.bus_8bit = 1'b1;
		em.luminance = 2'h2;
		cmp8(mode, em);
		// external reset: ignored without strap, needs over 10 us with it
		ext_reset_n = 1'b0;
		repeat (250) @(negedge mclk);
		cmp8({7'h0, busy_indicator}, 8'h00);
		reset_strap = 1'b1;
		repeat (190) @(negedge mclk);
		cmp8({7'h0, busy_indicator}, 8'h00);
		repeat (20) @(negedge mclk);
		cmp8({7'h0, busy_indicator}, 8'h01);
		cmp8(mode, MODE_RESET);
		ext_reset_n = 1'b1;
		wait_busy(CLEAR_MAX_CYC);
		rd(1'b0, st);
		cmp8(st, 8'h00);
		// split strobe style
		bs = 1'b1;
		bus_style_strap = 1'b1;
		par_en_rd_n = 1'b1;
		do_reset;
		wr(1'b0, 8'h81);
		wait_ready(st);
		wr(1'b1, 8'h42);
		wait_ready(st);
		cmp8(st, 8'h02);
		scan_t(7'h01, 8'h42);
		// serial link
		interface_strap = 1'b1;
		do_reset;
		host_u.frame(8'hf8, 8'h30, rx);
		wait_busy(200);
		host_u.frame(8'hf8, 8'h82, rx);
		wait_busy(200);
		host_u.frame(8'hfa, 8'h5a, rx);
		wait_busy(200);
		for (int i = 0; i < 3; i++)
			host_u.frame(bad[i], 8'h33, rx);
		host_u.frame(8'hfc, 8'h00, rx);
		cmp8(rx, 8'h03);
		scan_t(7'h02, 8'h5a);
		host_u.frame(8'hf8, 8'h82, rx);
		wait_busy(200);
		host_u.frame(8'hfe, 8'h00, rx);
		cmp8(rx, 8'h5a);
		wait_busy(200);
		wr(1'b1, 8'h77);
		repeat (3) @(negedge mclk);
		cmp8({7'h0, busy_indicator}, 8'h00);
		finish_test;
	end
endmodule // tb_top
